/* rtl/powerup_selftest_status.sv */
// Power-up self-test sequencer with indicator, service request and status logic.
//
// Contract
// - Every power-up starts a self-test of the mainframe and all cards before normal work.
// - All present units' error lights are lit from the start of the test until it ends.
// - A unit found faulty by the test keeps its error light lit afterwards.
// - With no fault found, all error lights go dark when the test completes.
// - Communication and settings errors from the bus side are reported to the controller.
// - Self-test hardware faults are reported only for cards, not for the mainframe.
// - A processor board fault at any time is fatal and stops the device.
// - Card hardware faults after the test are reported while the processor board works.
// - A card's selection light is lit exactly while that card is selected.
// - At self-test completion the service request line is asserted.
// - The addressed light follows talk or listen addressing, is off at reset, no software.
// - The restore command returns the mainframe and all cards to power-up state.
// - Both parties follow the general purpose instrument bus standard.
// - After a passing test the device enters immediate mode with service request set.
//
// Strobed register access and the register addresses were left to the implementer.
`default_nettype none
module powerup_selftest_status
  import selftest_pkg::*;
#(
  parameter int unsigned NUM_CARDS   = 6,
  parameter int unsigned TEST_CYCLES_P = TEST_CYCLES
) (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 resetn_i,
  // Register port
  input  wire reg_req_t             req_i,
  output logic [31:0]               rdata_o,
  // Pins from mainframe and cards
  input  wire logic [NUM_CARDS-1:0] card_present_i,
  input  wire logic [NUM_CARDS:0]   unit_done_i,
  input  wire logic [NUM_CARDS:0]   unit_fault_i,
  input  wire logic [NUM_CARDS-1:0] card_err_i,
  input  wire logic                 cpu_fault_i,
  // Bus interface logic
  input  wire logic                 init_i,
  input  wire logic                 comm_err_i,
  input  wire logic                 set_err_i,
  input  wire logic                 serial_poll_i,
  input  wire logic                 talk_addr_i,
  input  wire logic                 listen_addr_i,
  output logic                      cmd_ready_o,
  output logic                      srq_o,
  // Indicators and test control
  output logic [NUM_CARDS:0]        err_led_o,
  output logic [NUM_CARDS-1:0]      active_led_o,
  output logic                      addressed_led_o,
  output logic                      test_run_o,
  output logic                      irq_o
);
  localparam int unsigned NU = NUM_CARDS + 1;
  localparam int unsigned SW = 4 * NUM_CARDS + 3;

  // Decodes a slot number into one card bit; slot 0 selects none.
  function automatic logic [NUM_CARDS-1:0] slot_bit(input logic [SEL_W-1:0] s);
    logic [NUM_CARDS-1:0] r;
    r = '0;
    for (int i = 0; i < NUM_CARDS; i++)
    begin
      if (s == SEL_W'(i + 1))
      begin
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction : slot_bit

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [SW-1:0] meta;
  logic [SW-1:0] sync;
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      meta <= '0;
      sync <= '0;
    end
    else
    begin
      meta <= {cpu_fault_i, card_err_i, unit_fault_i, unit_done_i, card_present_i};
      sync <= meta;
    end
  end
  logic [NUM_CARDS-1:0] present_s;
  logic [NUM_CARDS:0]   done_s;
  logic [NUM_CARDS:0]   fault_s;
  logic [NUM_CARDS-1:0] card_err_s;
  logic                 cpu_fault_s;
  assign {cpu_fault_s, card_err_s, fault_s, done_s, present_s} = sync;
  logic [NUM_CARDS:0]   units;
  assign units = {present_s, 1'b1};

  // ----------------------------------------------------------------
  // Sequencer, faults, selection and service request
  // ----------------------------------------------------------------
  state_t               state, next_state;
  logic [31:0]          cnt, next_cnt;
  logic [NUM_CARDS:0]   fault_map, next_fault_map;
  logic [NUM_CARDS-1:0] card_err_q, next_card_err_q;
  logic [SEL_W-1:0]     sel, next_sel;
  logic                 srq, next_srq;
  logic                 addr_led, next_addr_led;
  event_t               ev;
  logic                 restore;
  logic [NUM_CARDS:0]   tfault;
  logic                 test_end;
  logic                 sel_wr;

  assign sel_wr  = req_i.we && req_i.addr == OFS_SEL;
  assign restore = state == ST_READY && (init_i ||
                   (req_i.we && req_i.addr == OFS_CTRL && req_i.wdata[CTRL_INIT_BIT]));

  always_comb
  begin
    next_state      = state;
    next_cnt        = cnt;
    next_fault_map  = fault_map;
    next_card_err_q = card_err_s;
    next_sel        = sel;
    next_srq        = srq;
    next_addr_led   = talk_addr_i || listen_addr_i;
    ev              = '0;
    tfault          = units & (fault_s | ~done_s);
    test_end        = ((done_s & units) == units) || cnt >= TEST_CYCLES_P - 1;
    if (serial_poll_i)
    begin
      next_srq = 1'b0;
    end
    case (state)
      ST_TEST:
      begin
        next_cnt = cnt + 32'h0000_0001;
        if (test_end)
        begin
          next_state     = ST_READY;
          next_fault_map = tfault;
          next_srq       = 1'b1;
          ev.test_done   = 1'b1;
          ev.card_fault  = |tfault[NUM_CARDS:1];
        end
      end
      ST_READY:
      begin
        if (restore)
        begin
          next_state     = ST_TEST;
          next_cnt       = '0;
          next_fault_map = '0;
          next_sel       = SEL_RST;
          next_srq       = 1'b0;
        end
        else
        begin
          if (|(card_err_s & ~card_err_q & present_s))
          begin
            next_fault_map[NUM_CARDS:1] = fault_map[NUM_CARDS:1] | (card_err_s & present_s);
            ev.hw_err = 1'b1;
            next_srq  = 1'b1;
          end
          ev.comm_err = comm_err_i;
          ev.set_err  = set_err_i;
          if (sel_wr)
          begin
            if ((slot_bit(req_i.wdata[SEL_W-1:0]) & ~present_s) != '0)
            begin
              ev.set_err = 1'b1;
            end
            else
            begin
              next_sel = req_i.wdata[SEL_W-1:0];
            end
          end
          if (ev.comm_err || ev.set_err)
          begin
            next_srq = 1'b1;
          end
        end
      end
      ST_HALT:
      begin
        next_srq = 1'b0;
        next_sel = SEL_RST;
      end
      default:
      begin
        next_state = ST_TEST;
      end
    endcase
    if (cpu_fault_s)
    begin
      next_state   = ST_HALT;
      next_fault_map[0] = 1'b1;
      ev.fatal     = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state      <= ST_TEST;
      cnt        <= '0;
      fault_map  <= '0;
      card_err_q <= '0;
      sel        <= SEL_RST;
      srq        <= 1'b0;
      addr_led   <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      cnt        <= next_cnt;
      fault_map  <= next_fault_map;
      card_err_q <= next_card_err_q;
      sel        <= next_sel;
      srq        <= next_srq;
      addr_led   <= next_addr_led;
    end
  end

  always_comb
  begin
    case (state)
      ST_TEST:  err_led_o = units;
      ST_READY: err_led_o = fault_map & units;
      default:  err_led_o = fault_map;
    endcase
  end
  assign active_led_o    = state == ST_READY ? slot_bit(sel) & present_s : '0;
  assign addressed_led_o = addr_led;
  assign srq_o           = srq;
  assign cmd_ready_o     = state == ST_READY;
  assign test_run_o      = state == ST_TEST;

  // ----------------------------------------------------------------
  // Interrupt status and register reads
  // ----------------------------------------------------------------
  event_t      irq_stat, next_irq_stat;
  event_t      irq_en, next_irq_en;
  logic [31:0] rdata, next_rdata;

  always_comb
  begin
    next_irq_stat = irq_stat;
    next_irq_en   = irq_en;
    next_rdata    = '0;
    if (req_i.we && req_i.addr == OFS_IRQ_CLR)
    begin
      next_irq_stat = irq_stat & ~event_t'(req_i.wdata[5:0]);
    end
    next_irq_stat = next_irq_stat | ev;
    if (req_i.we && req_i.addr == OFS_IRQ_EN)
    begin
      next_irq_en = event_t'(req_i.wdata[5:0]);
    end
    if (req_i.re)
    begin
      case (req_i.addr)
        OFS_SEL:      next_rdata = 32'(sel);
        OFS_STATUS:   next_rdata = (32'(state) << STAT_STATE_POS) |
                                   (32'(fault_map) << STAT_FAULT_POS) |
                                   (32'(present_s) << STAT_PRES_POS);
        OFS_IRQ_STAT: next_rdata = 32'(irq_stat);
        OFS_IRQ_EN:   next_rdata = 32'(irq_en);
        default:      next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      irq_stat <= '0;
      irq_en   <= IRQ_EN_RST;
      rdata    <= '0;
    end
    else
    begin
      irq_stat <= next_irq_stat;
      irq_en   <= next_irq_en;
      rdata    <= next_rdata;
    end
  end
  assign rdata_o = rdata;
  assign irq_o   = |(irq_stat & irq_en);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_test_ends;
    state == ST_TEST ##1 state == ST_READY;
  endsequence

  AST_LEDS_IN_TEST: assert property (state == ST_TEST |-> err_led_o == units)
    else $error("error lights not all lit during self-test");
  AST_CLEAN_PASS: assert property (s_test_ends ##0 $past(tfault) == '0 |->
    err_led_o == '0 && !$stable(state))
    else $error("error lights stay lit after a clean self-test");
  AST_FAULT_KEPT: assert property (state == ST_READY && fault_map[0] |-> err_led_o[0])
    else $error("mainframe fault light dark after failed test");
  AST_SRQ_DONE: assert property (s_test_ends |-> srq_o && irq_stat.test_done)
    else $error("service request missing at self-test completion");
  AST_SRQ_HOLD: assert property (srq_o && !serial_poll_i && state == ST_READY &&
    !restore && !cpu_fault_s |=> srq_o)
    else $error("service request dropped without a serial poll");
  AST_NO_CMD_TEST: assert property (state == ST_TEST |-> !cmd_ready_o ##1
    (state != ST_TEST || !cmd_ready_o))
    else $error("commands accepted during self-test");
  AST_FATAL: assert property (cpu_fault_s |=> state == ST_HALT ##1 state == ST_HALT)
    else $error("processor board fault did not halt the device");
  AST_ADDR_LED: assert property ((talk_addr_i || listen_addr_i) |=> addressed_led_o)
    else $error("addressed light missed talk or listen addressing");
  AST_SEL_LED: assert property (state == ST_READY |-> $onehot0(active_led_o) &&
    active_led_o == (slot_bit(sel) & present_s))
    else $error("selection light disagrees with selected card");
  AST_RESTORE: assert property (restore && !cpu_fault_s |=> state == ST_TEST &&
    fault_map == '0 && sel == SEL_RST)
    else $error("restore did not return to power-up state");
  AST_NO_MF_REPORT: assert property (s_test_ends ##0 $past(tfault[NUM_CARDS:1]) == '0 |->
    !$past(ev.card_fault))
    else $error("mainframe self-test fault reported as card fault");
endmodule : powerup_selftest_status
`default_nettype wire

/* rtl/selftest_pkg.sv */
// Constants and types shared by the power-up self-test and status block.
`default_nettype none
package selftest_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned TEST_TIME_NS  = 2_000_000;
  localparam int unsigned TEST_CYCLES   = TEST_TIME_NS / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_SEL      = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h14;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_INIT_BIT  = 0;
  localparam int unsigned STAT_STATE_POS = 0;
  localparam int unsigned STAT_FAULT_POS = 8;
  localparam int unsigned STAT_PRES_POS  = 16;
  localparam int unsigned SEL_W          = 3;
  localparam logic [SEL_W-1:0] SEL_RST   = 3'h0;
  localparam logic [5:0] IRQ_EN_RST      = 6'h00;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_TEST, ST_READY, ST_HALT} state_t;
  // Sticky events, one bit each, same layout in status, clear and enable.
  typedef struct packed {
    logic fatal;
    logic hw_err;
    logic set_err;
    logic comm_err;
    logic card_fault;
    logic test_done;
  } event_t;
  // Register port request from the command processor.
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        we;
    logic        re;
  } reg_req_t;
endpackage : selftest_pkg
`default_nettype wire

/* dv/self_test_units.sv */
// Behavioural model of the mainframe and card self-test circuits.
`default_nettype none
module self_test_units
#(
  parameter int unsigned NUM_UNITS  = 7,
  parameter int unsigned DONE_DELAY = 10
) (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 resetn_i,
  // Test control and results
  input  wire logic                 test_run_i,
  input  wire logic [NUM_UNITS-1:0] fault_map_i,
  output logic      [NUM_UNITS-1:0] done_o,
  output logic      [NUM_UNITS-1:0] fault_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned count;
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      count <= 0;
    else if (!test_run_i)
      count <= 0;
    else if (count < DONE_DELAY)
      count <= count + 1;
  end
  // Results are only shown once a unit has finished, as the real circuits do.
  assign done_o  = (count == DONE_DELAY) ? '1 : '0;
  assign fault_o = (count == DONE_DELAY) ? fault_map_i : '0;
endmodule : self_test_units
`default_nettype wire

/* dv/powerup_selftest_status_test.sv */
// Self-checking bench for the power-up self-test and status block.
`default_nettype none
module powerup_selftest_status_test
  import selftest_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned NC = 6;
  typedef struct packed {
    logic        we;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] exp;
  } row_t;
  localparam row_t ROWS [6] = '{
    '{1'b1, OFS_IRQ_EN, 32'h0000_003F, 32'h0000_003F},
    '{1'b1, OFS_SEL, 32'h0000_0001, 32'h0000_0001},
    '{1'b1, OFS_SEL, 32'h0000_0004, 32'h0000_0001},
    '{1'b0, OFS_IRQ_STAT, 32'h0000_0000, 32'h0000_000B},
    '{1'b1, OFS_IRQ_CLR, 32'h0000_003F, 32'h0000_0000},
    '{1'b0, 8'h18, 32'h0000_0000, 32'h0000_0000}};
  logic              clk_i, resetn_i, cpu_fault_i, init_i, comm_err_i, set_err_i;
  logic              serial_poll_i, talk_addr_i, listen_addr_i, cmd_ready_o, srq_o;
  logic              addressed_led_o, test_run_o, irq_o;
  reg_req_t          req_i;
  logic [31:0]       rdata_o, data;
  logic [NC-1:0]     card_present_i, card_err_i, active_led_o;
  logic [NC:0]       unit_done_i, unit_fault_i, err_led_o, fault_map;
  int                n_fail, n_compared;

  powerup_selftest_status #(.NUM_CARDS(NC), .TEST_CYCLES_P(50)) powerup_selftest_status_i (
    .clk_i(clk_i), .resetn_i(resetn_i), .req_i(req_i), .rdata_o(rdata_o),
    .card_present_i(card_present_i), .unit_done_i(unit_done_i), .unit_fault_i(unit_fault_i),
    .card_err_i(card_err_i), .cpu_fault_i(cpu_fault_i), .init_i(init_i),
    .comm_err_i(comm_err_i), .set_err_i(set_err_i), .serial_poll_i(serial_poll_i),
    .talk_addr_i(talk_addr_i), .listen_addr_i(listen_addr_i), .cmd_ready_o(cmd_ready_o),
    .srq_o(srq_o), .err_led_o(err_led_o), .active_led_o(active_led_o),
    .addressed_led_o(addressed_led_o), .test_run_o(test_run_o), .irq_o(irq_o));
  self_test_units #(.NUM_UNITS(NC + 1), .DONE_DELAY(10)) self_test_units_i (
    .clk_i(clk_i), .resetn_i(resetn_i), .test_run_i(test_run_o),
    .fault_map_i(fault_map), .done_o(unit_done_i), .fault_o(unit_fault_i));

  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    req_i <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clk_i);
    req_i <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    req_i <= '{addr: a, wdata: 32'h0000_0000, we: 1'b0, re: 1'b1};
    @(posedge clk_i);
    req_i <= '0;
    #1;
    d = rdata_o;
  endtask : rd
  task automatic wait_ready(input logic want);
    for (int i = 0; i < 500 && cmd_ready_o !== want; i++)
      @(posedge clk_i) #1;
    if (cmd_ready_o !== want)
    begin
      n_fail++;
      $display("unexpected at %0t: ready wait ran out", $time);
      tally_and_finish();
    end
  endtask : wait_ready
  task automatic poll();
    @(posedge clk_i);
    serial_poll_i <= 1'b1;
    @(posedge clk_i);
    serial_poll_i <= 1'b0;
    #1;
    chk(srq_o, 1'b0);
  endtask : poll

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    n_fail = 0;
    n_compared = 0;
    resetn_i = 1'b0;
    req_i = '0;
    {cpu_fault_i, init_i, comm_err_i, set_err_i} = 4'h0;
    {serial_poll_i, talk_addr_i, listen_addr_i} = 3'h0;
    card_present_i = 6'h03;
    card_err_i = 6'h00;
    fault_map = 7'h05;
    repeat (20) @(posedge clk_i);
    chk(err_led_o, 7'h01);
    chk(srq_o, 1'b0);
    chk(addressed_led_o, 1'b0);
    resetn_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    init_i <= 1'b1;
    @(posedge clk_i);
    init_i <= 1'b0;
    #1;
    chk(test_run_o, 1'b1);
    chk(cmd_ready_o, 1'b0);
    chk(err_led_o, 7'h07);
    wait_ready(1'b1);
    chk(srq_o, 1'b1);
    chk(err_led_o, 7'h05);
    rd(OFS_STATUS, data);
    chk(data & 32'h0000_7F03, 32'h0000_0501);
    for (int k = 0; k < 6; k++)
    begin
      if (ROWS[k].we)
        wr(ROWS[k].addr, ROWS[k].wdata);
      rd(ROWS[k].addr, data);
      chk(data, ROWS[k].exp);
    end
    chk(active_led_o, 6'h01);
    chk(irq_o, 1'b0);
    poll();
    @(posedge clk_i);
    {comm_err_i, set_err_i} <= 2'b11;
    @(posedge clk_i);
    {comm_err_i, set_err_i} <= 2'b00;
    #1;
    chk(srq_o, 1'b1);
    chk(irq_o, 1'b1);
    rd(OFS_IRQ_STAT, data);
    chk(data, 32'h0000_000C);
    wr(OFS_IRQ_EN, 32'h0000_0000);
    #1;
    chk(irq_o, 1'b0);
    poll();
    @(posedge clk_i);
    talk_addr_i <= 1'b1;
    @(posedge clk_i) #1;
    chk(addressed_led_o, 1'b1);
    {talk_addr_i, listen_addr_i} <= 2'b01;
    @(posedge clk_i);
    listen_addr_i <= 1'b0;
    #1;
    chk(addressed_led_o, 1'b1);
    @(posedge clk_i) #1;
    chk(addressed_led_o, 1'b0);
    card_err_i <= 6'h01;
    for (int i = 0; i < 10 && err_led_o !== 7'h07; i++)
      @(posedge clk_i) #1;
    chk(err_led_o, 7'h07);
    chk(srq_o, 1'b1);
    rd(OFS_IRQ_STAT, data);
    chk(data & 32'h0000_0010, 32'h0000_0010);
    card_err_i <= 6'h00;
    fault_map <= 7'h00;
    @(posedge clk_i);
    init_i <= 1'b1;
    @(posedge clk_i);
    init_i <= 1'b0;
    @(posedge clk_i) #1;
    chk(test_run_o, 1'b1);
    chk(err_led_o, 7'h07);
    chk(srq_o, 1'b0);
    chk(active_led_o, 6'h00);
    wait_ready(1'b1);
    chk(err_led_o, 7'h00);
    chk(srq_o, 1'b1);
    // Let the synchronised done pins fall before restarting by register write.
    repeat (4) @(posedge clk_i);
    wr(OFS_CTRL, 32'h0000_0001);
    #1;
    chk(test_run_o, 1'b1);
    chk(srq_o, 1'b0);
    wait_ready(1'b1);
    chk(err_led_o, 7'h00);
    chk(srq_o, 1'b1);
    cpu_fault_i <= 1'b1;
    wait_ready(1'b0);
    rd(OFS_STATUS, data);
    chk(data & 32'h0000_0003, 32'h0000_0002);
    chk(err_led_o[0], 1'b1);
    chk(srq_o, 1'b0);
    tally_and_finish();
  end
endmodule : powerup_selftest_status_test
`default_nettype wire
